//--- common/tape_hdr_consts.svh
// Purpose: Constants for the command header decoder
// Assumes: 16-bit header words, four-word packets
// Notes: Offsets are word indices on the strobed register port
`ifndef TAPE_HDR_CONSTS_SVH
`define TAPE_HDR_CONSTS_SVH
`define HDR_ACK_BIT 15
`define HDR_CLRVOL_BIT 14
`define HDR_REVORD_BIT 13
`define HDR_SWAP_BIT 12
`define HDR_MODE_HI 11
`define HDR_MODE_LO 8
`define HDR_FMT_HI 7
`define HDR_FMT_LO 5
`define HDR_CODE_HI 4
`define HDR_CODE_LO 0
`define FMT_INT_OFF 3'h0
`define FMT_INT_ON 3'h4
`define CODE_READ 5'h01
`define CODE_WRCHAR 5'h04
`define CODE_WRITE 5'h05
`define CODE_WRMEM 5'h06
`define CODE_POSITION 5'h08
`define CODE_FORMAT 5'h09
`define CODE_INIT 5'h0b
`define CODE_STATUS 5'h0f
`define MODE_0 4'h0
`define MODE_1 4'h1
`define MODE_2 4'h2
`define MODE_3 4'h3
`define MODE_4 4'h4
`define CLASS_LONG 2'h0
`define PKT_WORDS 3'h4
`define PKT_WORDS_PARAM 3'h2
`define PKT_WORDS_HDR 3'h1
`define LAST_WORD_IDX 2'h3
`define REG_STATUS 4'h0
`define REG_MASK 4'h1
`define REG_CTRL 4'h2
`define REG_STATE 4'h3
`define EV_DONE 0
`define EV_REJECT 1
`define EV_PARITY 2
`define EV_W 3
`define CTRL_ADDR22 0
`endif

//--- common/tape_hdr_pkg.sv
// Purpose: Types shared by the header decoder and byte mapper
// Assumes: Nothing beyond the constants header
// Notes: Carriers are packed structs
package tape_hdr_pkg;
	typedef enum logic [1:0] {ST_COLLECT, ST_DECODE} phase_e;
	typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE_CHAR, OP_WRITE,
		OP_POSITION, OP_FORMAT, OP_INIT, OP_STATUS} op_e;
	typedef enum logic [3:0] {MV_NONE, MV_SPACE_FWD, MV_SPACE_REV,
		MV_READ_FWD, MV_READ_REV, MV_WRITE, MV_ERASE, MV_MARK,
		MV_SKIP_FWD, MV_SKIP_REV, MV_REWIND, MV_INIT, MV_LOAD_CHAR,
		MV_STATUS} motion_e;
	typedef struct packed {
		op_e op;
		logic [3:0] mode;
		logic ackOwner;
		logic clearVolumeCheck;
		logic reverseRereadOrder;
		logic byteOrderSwap;
		logic completionInterruptEnable;
		logic [2:0] packetWords;
		motion_e step0;
		motion_e step1;
		motion_e step2;
		logic [21:0] bufAddr;
		logic [15:0] byteCount;
	} cmd_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} reg_req_s;
	typedef struct packed {
		logic valid;
		logic [15:0] idx;
	} byte_req_s;
	typedef struct packed {
		logic valid;
		logic [21:0] addr;
	} byte_ans_s;
endpackage

//--- core/byte_lane_mapper.sv
// Purpose: Maps a record byte number to a memory byte address
// Assumes: Command fields stable while bytes move
// Notes: One cycle from request to answer
`timescale 1ns/1ns
`default_nettype none
module byte_lane_mapper #(
	parameter int ADDR_W = 22
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire tape_hdr_pkg::cmd_s cmd,
	input wire tape_hdr_pkg::byte_req_s byteReq,
	output tape_hdr_pkg::byte_ans_s byteAns
);
	typedef struct packed {
		tape_hdr_pkg::byte_ans_s ans;
	} map_state_s;
	map_state_s s_q;
	map_state_s s_d;
	logic reverseRead;
	logic dataOp;
	logic [15:0] recNum;
	logic [ADDR_W-1:0] byteAddr;
	always_comb begin
		reverseRead = (cmd.step0 == tape_hdr_pkg::MV_READ_REV) ||
			(cmd.step1 == tape_hdr_pkg::MV_READ_REV);
		dataOp = (cmd.op == tape_hdr_pkg::OP_READ) ||
			(cmd.op == tape_hdr_pkg::OP_WRITE);
		// First byte received lands in the last position
		recNum = reverseRead ? 16'(cmd.byteCount - 16'h0001 - byteReq.idx)
			: byteReq.idx;
		byteAddr = ADDR_W'(cmd.bufAddr + 22'(recNum));
		// Lane-swapped order (address bit 0 inverted) only when moving data
		if (dataOp && cmd.byteOrderSwap) begin
			byteAddr[0] = ~byteAddr[0];
		end
		s_d = s_q;
		s_d.ans.valid = byteReq.valid;
		if (byteReq.valid) begin
			s_d.ans.addr = 22'(byteAddr);
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign byteAns = s_q.ans;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_reverse_first_last:
	assert property (byteReq.valid && reverseRead && !cmd.byteOrderSwap &&
		byteReq.idx == 16'h0000 |=> byteAns.valid &&
		byteAns.addr == 22'($past(cmd.bufAddr) +
		22'($past(cmd.byteCount)) - 22'h00_0001))
	else $error("reverse read first byte not at last position");
	a_swap_lane_flip:
	assert property (byteReq.valid && dataOp && !reverseRead &&
		cmd.byteOrderSwap |=> byteAns.addr[0] !=
		$past(cmd.bufAddr[0] ^ byteReq.idx[0]))
	else $error("byte swap lane not applied");
endmodule
`default_nettype wire

//--- core/tape_command_header_decoder.sv
// Purpose: Collects a command packet and decodes its header word
// Assumes: Packet words arrive one per pktValid while pktReady
// Notes: Rejected packets never raise cmdValid
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tape_hdr_consts.svh"
// Function
// - Acknowledge hands message buffer to coupler
// - Bits 14..12 are clear, reorder, swap
// - Reorder bit reverses reread step sequence
// - Bits 11..8 select command variant
// - Format 000 interrupt off, 100 on
// - Code bits 4..3 give packet length
// - Read forward, reverse, reread previous, next
// - Write characteristics loads buffer address
// - Write data or retry with erase
// - Position spaces, skips marks, rewinds
// - Format writes mark, erases, or retries
// - Initialize transport, get status immediate
// - Swap set starts even, else odd (code inverts address bit 0: an even buffer starts odd)
// - Swap applies to data transfers only
// - Record bytes numbered from tape start
// - Reverse read fills buffer downward
// - Always fetch four words, reject parity
module tape_command_header_decoder #(
	parameter int ADDR_W = 22
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic pktValid,
	input wire logic [15:0] pktWord,
	input wire logic pktParityErr,
	output logic pktReady,
	input wire logic msgBufRelease,
	output logic msgBufOwned,
	output tape_hdr_pkg::cmd_s cmd,
	output logic cmdValid,
	output logic cmdReject,
	input wire tape_hdr_pkg::byte_req_s byteReq,
	output tape_hdr_pkg::byte_ans_s byteAns,
	input wire tape_hdr_pkg::reg_req_s regReq,
	output logic [15:0] regRdata,
	output logic irq
);
	typedef struct packed {
		tape_hdr_pkg::phase_e phase;
		logic [1:0] wordIdx;
		logic [3:0][15:0] words;
		logic parityBad;
		tape_hdr_pkg::cmd_s cmd;
		logic cmdValid;
		logic cmdReject;
		logic owned;
		logic [`EV_W-1:0] status;
		logic [`EV_W-1:0] mask;
		logic addr22;
		logic [15:0] rdata;
	} dec_state_s;

	dec_state_s s_q;
	dec_state_s s_d;
	tape_hdr_pkg::cmd_s dec;
	logic [`EV_W-1:0] evt;
	logic fmtOk;
	logic lastTaken;

	function automatic tape_hdr_pkg::cmd_s decodeHeader(
		input logic [3:0][15:0] w,
		input logic addr22
	);
		tape_hdr_pkg::cmd_s c;
		logic [4:0] code;
		logic [3:0] mode;
		tape_hdr_pkg::motion_e tmp;
		c = '0;
		code = w[0][`HDR_CODE_HI:`HDR_CODE_LO];
		mode = w[0][`HDR_MODE_HI:`HDR_MODE_LO];
		c.mode = mode;
		c.ackOwner = w[0][`HDR_ACK_BIT];
		c.clearVolumeCheck = w[0][`HDR_CLRVOL_BIT];
		c.reverseRereadOrder = w[0][`HDR_REVORD_BIT];
		c.byteOrderSwap = w[0][`HDR_SWAP_BIT];
		c.completionInterruptEnable =
			w[0][`HDR_FMT_HI:`HDR_FMT_LO] == `FMT_INT_ON;
		c.packetWords = (code[4:3] == `CLASS_LONG) ? `PKT_WORDS
			: `PKT_WORDS_PARAM;
		c.bufAddr = {w[2][5:0], w[1]};
		if (!addr22) begin
			c.bufAddr[21:18] = 4'h0;
		end
		c.byteCount = w[3];
		c.op = tape_hdr_pkg::OP_NONE;
		c.step0 = tape_hdr_pkg::MV_NONE;
		c.step1 = tape_hdr_pkg::MV_NONE;
		c.step2 = tape_hdr_pkg::MV_NONE;
		case (code)
			`CODE_READ: begin
				c.op = tape_hdr_pkg::OP_READ;
				case (mode)
					`MODE_0: c.step0 = tape_hdr_pkg::MV_READ_FWD;
					`MODE_1: c.step0 = tape_hdr_pkg::MV_READ_REV;
					`MODE_2: begin
						c.step0 = tape_hdr_pkg::MV_SPACE_REV;
						c.step1 = tape_hdr_pkg::MV_READ_FWD;
					end
					`MODE_3: begin
						c.step0 = tape_hdr_pkg::MV_SPACE_FWD;
						c.step1 = tape_hdr_pkg::MV_READ_REV;
					end
					default: c.op = tape_hdr_pkg::OP_NONE;
				endcase
				if (c.reverseRereadOrder && (mode == `MODE_2 ||
					mode == `MODE_3)) begin
					tmp = c.step0;
					c.step0 = c.step1;
					c.step1 = tmp;
				end
			end
			`CODE_WRCHAR: begin
				if (mode == `MODE_0) begin
					c.op = tape_hdr_pkg::OP_WRITE_CHAR;
					c.step0 = tape_hdr_pkg::MV_LOAD_CHAR;
				end
			end
			`CODE_WRITE: begin
				c.op = tape_hdr_pkg::OP_WRITE;
				case (mode)
					`MODE_0: c.step0 = tape_hdr_pkg::MV_WRITE;
					`MODE_2: begin
						c.step0 = tape_hdr_pkg::MV_SPACE_REV;
						c.step1 = tape_hdr_pkg::MV_ERASE;
						c.step2 = tape_hdr_pkg::MV_WRITE;
					end
					default: c.op = tape_hdr_pkg::OP_NONE;
				endcase
			end
			`CODE_POSITION: begin
				c.op = tape_hdr_pkg::OP_POSITION;
				case (mode)
					`MODE_0: c.step0 = tape_hdr_pkg::MV_SPACE_FWD;
					`MODE_1: c.step0 = tape_hdr_pkg::MV_SPACE_REV;
					`MODE_2: c.step0 = tape_hdr_pkg::MV_SKIP_FWD;
					`MODE_3: c.step0 = tape_hdr_pkg::MV_SKIP_REV;
					`MODE_4: begin
						c.step0 = tape_hdr_pkg::MV_REWIND;
						c.packetWords = `PKT_WORDS_HDR;
					end
					default: c.op = tape_hdr_pkg::OP_NONE;
				endcase
			end
			`CODE_FORMAT: begin
				c.op = tape_hdr_pkg::OP_FORMAT;
				case (mode)
					`MODE_0: c.step0 = tape_hdr_pkg::MV_MARK;
					`MODE_1: c.step0 = tape_hdr_pkg::MV_ERASE;
					`MODE_2: begin
						c.step0 = tape_hdr_pkg::MV_SPACE_REV;
						c.step1 = tape_hdr_pkg::MV_ERASE;
						c.step2 = tape_hdr_pkg::MV_MARK;
					end
					default: c.op = tape_hdr_pkg::OP_NONE;
				endcase
			end
			`CODE_INIT: begin
				if (mode == `MODE_0) begin
					c.op = tape_hdr_pkg::OP_INIT;
					c.step0 = tape_hdr_pkg::MV_INIT;
					c.packetWords = `PKT_WORDS_HDR;
				end
			end
			`CODE_STATUS: begin
				if (mode == `MODE_0) begin
					c.op = tape_hdr_pkg::OP_STATUS;
					c.step0 = tape_hdr_pkg::MV_STATUS;
					c.packetWords = `PKT_WORDS_HDR;
				end
			end
			// Subsystem memory write and all others are refused
			default: c.op = tape_hdr_pkg::OP_NONE;
		endcase
		if (c.op == tape_hdr_pkg::OP_NONE) begin
			c.step0 = tape_hdr_pkg::MV_NONE;
			c.step1 = tape_hdr_pkg::MV_NONE;
			c.step2 = tape_hdr_pkg::MV_NONE;
		end
		return c;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.cmdValid = 1'b0;
		s_d.cmdReject = 1'b0;
		s_d.rdata = 16'h0000;
		evt = '0;
		dec = decodeHeader(s_q.words, s_q.addr22);
		fmtOk = (s_q.words[0][`HDR_FMT_HI:`HDR_FMT_LO] == `FMT_INT_OFF) ||
			(s_q.words[0][`HDR_FMT_HI:`HDR_FMT_LO] == `FMT_INT_ON);
		if (msgBufRelease) begin
			s_d.owned = 1'b0;
		end
		unique case (s_q.phase)
			tape_hdr_pkg::ST_COLLECT: begin
				if (pktValid) begin
					s_d.words[s_q.wordIdx] = pktWord;
					s_d.parityBad = s_q.parityBad | pktParityErr;
					s_d.wordIdx = 2'(s_q.wordIdx + 2'h1);
					if (s_q.wordIdx == `LAST_WORD_IDX) begin
						s_d.phase = tape_hdr_pkg::ST_DECODE;
					end
				end
			end
			tape_hdr_pkg::ST_DECODE: begin
				s_d.phase = tape_hdr_pkg::ST_COLLECT;
				s_d.wordIdx = 2'h0;
				s_d.parityBad = 1'b0;
				if (s_q.parityBad) begin
					s_d.cmdReject = 1'b1;
					evt[`EV_PARITY] = 1'b1;
					evt[`EV_REJECT] = 1'b1;
				end else begin
					// Ownership passes even if the command is refused
					if (dec.ackOwner) begin
						s_d.owned = 1'b1;
					end
					if (dec.op == tape_hdr_pkg::OP_NONE || !fmtOk) begin
						s_d.cmdReject = 1'b1;
						evt[`EV_REJECT] = 1'b1;
					end else begin
						s_d.cmd = dec;
						s_d.cmdValid = 1'b1;
						evt[`EV_DONE] = 1'b1;
					end
				end
			end
		endcase
		if (regReq.wr) begin
			unique case (regReq.addr)
				`REG_STATUS: s_d.status = s_q.status &
					~regReq.wdata[`EV_W-1:0];
				`REG_MASK: s_d.mask = regReq.wdata[`EV_W-1:0];
				`REG_CTRL: s_d.addr22 = regReq.wdata[`CTRL_ADDR22];
				default: ;
			endcase
		end
		// New events win over a clear in the same cycle
		s_d.status = s_d.status | evt;
		if (regReq.rd) begin
			unique case (regReq.addr)
				`REG_STATUS: s_d.rdata = 16'(s_q.status);
				`REG_MASK: s_d.rdata = 16'(s_q.mask);
				`REG_CTRL: s_d.rdata = 16'(s_q.addr22);
				`REG_STATE: s_d.rdata = {7'h00, s_q.owned,
					s_q.cmd.mode, 1'b0, s_q.cmd.op};
				default: s_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pktReady = s_q.phase == tape_hdr_pkg::ST_COLLECT;
	assign msgBufOwned = s_q.owned;
	assign cmd = s_q.cmd;
	assign cmdValid = s_q.cmdValid;
	assign cmdReject = s_q.cmdReject;
	assign regRdata = s_q.rdata;
	assign irq = |(s_q.status & s_q.mask);
	assign lastTaken = pktValid && pktReady && s_q.wordIdx == 2'h3;

	byte_lane_mapper #(
		.ADDR_W(ADDR_W)
	) u_mapper (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.cmd(s_q.cmd),
		.byteReq(byteReq),
		.byteAns(byteAns)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence lastWord;
		lastTaken;
	endsequence
	sequence decodeGood;
		s_q.phase == tape_hdr_pkg::ST_DECODE && !s_q.parityBad;
	endsequence

	a_four_words_fetched:
	assert property ((cmdValid || cmdReject) |-> $past(lastTaken, 2))
	else $error("command decided without four words");
	a_parity_rejects:
	assert property (lastWord ##0 (s_q.parityBad || pktParityErr) |=>
		##1 (cmdReject && !cmdValid))
	else $error("parity error not rejected");
	a_ack_takes_buffer:
	assert property (decodeGood ##0 s_q.words[0][15] |=> msgBufOwned)
	else $error("acknowledge did not hand over buffer");
	a_flag_bits_decode:
	assert property (cmdValid |-> {cmd.clearVolumeCheck,
		cmd.reverseRereadOrder, cmd.byteOrderSwap} ==
		$past(s_q.words[0][14:12]))
	else $error("device dependent bits wrong");
	a_int_format_field:
	assert property (cmdValid |-> cmd.completionInterruptEnable ==
		($past(s_q.words[0][7:5]) == 3'h4))
	else $error("interrupt enable format wrong");
	a_undefined_refused:
	assert property (decodeGood ##0 (s_q.words[0][4:0] == 5'h06) |=>
		cmdReject && !cmdValid)
	else $error("undefined command not refused");
	a_long_packet_len:
	assert property (cmdValid && $past(s_q.words[0][4:3]) == 2'h0 |->
		cmd.packetWords == 3'h4)
	else $error("long packet length wrong");
	a_reread_reordered:
	assert property (cmdValid && cmd.op == tape_hdr_pkg::OP_READ &&
		cmd.mode == 4'h2 && cmd.reverseRereadOrder |->
		cmd.step0 == tape_hdr_pkg::MV_READ_FWD &&
		cmd.step1 == tape_hdr_pkg::MV_SPACE_REV)
	else $error("reread order not reversed");
	a_write_retry_steps:
	assert property (cmdValid && cmd.op == tape_hdr_pkg::OP_WRITE &&
		cmd.mode == 4'h2 |-> cmd.step0 == tape_hdr_pkg::MV_SPACE_REV &&
		cmd.step1 == tape_hdr_pkg::MV_ERASE &&
		cmd.step2 == tape_hdr_pkg::MV_WRITE)
	else $error("write retry steps wrong");
	a_rewind_mode:
	assert property (cmdValid && cmd.op == tape_hdr_pkg::OP_POSITION &&
		cmd.mode == 4'h4 |-> cmd.step0 == tape_hdr_pkg::MV_REWIND)
	else $error("rewind not decoded");
	a_event_sets_status:
	assert property (cmdReject |-> s_q.status[`EV_REJECT])
	else $error("reject event not recorded");
	a_reject_keeps_cmd:
	assert property (cmdReject |-> $stable(cmd))
	else $error("refused packet changed command");
endmodule
`default_nettype wire

//--- dv/host_pkt_model.sv
// Purpose: Host side model that hands four-word packets to the decoder
// Assumes: A word is taken on an edge with pktValid and pktReady high
// Notes: Idle word lines show the inverse of the last word
`timescale 1ns/1ns
`default_nettype none
module host_pkt_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic pktReady,
	input wire logic go,
	input wire logic slow,
	input wire logic [3:0][15:0] words,
	input wire logic [3:0] perr,
	output logic pktValid,
	output logic [15:0] pktWord,
	output logic pktParityErr,
	output logic busy
);
	logic [3:0][15:0] wq;
	logic [3:0] pq;
	logic [1:0] n;
	logic gap;
	assign busy = pktValid | gap;
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pktValid <= 1'b0;
			gap <= 1'b0;
			n <= 2'h0;
			pktWord <= 16'h0000;
			pktParityErr <= 1'b0;
		end else if (go && !busy) begin
			wq <= words;
			pq <= perr;
			pktValid <= 1'b1;
			pktWord <= words[0];
			pktParityErr <= perr[0];
			n <= 2'h1;
		end else if (gap) begin
			gap <= 1'b0;
			pktValid <= 1'b1;
			pktWord <= wq[n];
			pktParityErr <= pq[n];
			n <= n + 2'h1;
		end else if (pktValid && pktReady) begin
			if (n == 2'h0) begin
				pktValid <= 1'b0;
				pktWord <= ~pktWord;
				pktParityErr <= ~pktParityErr;
			end else if (slow) begin
				gap <= 1'b1;
				pktValid <= 1'b0;
				pktWord <= ~pktWord;
			end else begin
				pktWord <= wq[n];
				pktParityErr <= pq[n];
				n <= n + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/tape_command_header_decoder_tb_top.sv
// Purpose: Self-checking bench for the command header decoder
// Assumes: Host model feeds packets, bench drives the register port
// Notes: One scoreboard queue per kind of result
`timescale 1ns/1ns
`default_nettype none
module tape_command_header_decoder_tb_top;
	typedef struct packed {
		logic rej;
		logic [52:0] key;
		logic rr;
		logic [7:0] st;
	} exp_s;
	logic ref_clk, nrst, pktValid, pktParityErr, pktReady, go, busy, slow;
	logic msgBufRelease, msgBufOwned, cmdValid, cmdReject, irq, rdSeen, a22;
	logic [15:0] pktWord, regRdata, h, cnt;
	logic [21:0] ba, k;
	logic [3:0][15:0] words;
	logic [3:0] perr;
	tape_hdr_pkg::cmd_s cmd;
	tape_hdr_pkg::byte_req_s byteReq;
	tape_hdr_pkg::byte_ans_s byteAns;
	tape_hdr_pkg::reg_req_s regReq;
	exp_s cq[$];
	logic [21:0] bq[$];
	logic [15:0] rq[$];
	logic [15:0] hdrs[6] = '{16'h0001, 16'h0101, 16'h1001, 16'h1005,
		16'h1108, 16'h2201};
	int miscompares, cmp_count, resCount;
	tape_command_header_decoder dut (.ref_clk(ref_clk), .nrst(nrst),
		.pktValid(pktValid), .pktWord(pktWord), .pktParityErr(pktParityErr),
		.pktReady(pktReady), .msgBufRelease(msgBufRelease),
		.msgBufOwned(msgBufOwned), .cmd(cmd), .cmdValid(cmdValid),
		.cmdReject(cmdReject), .byteReq(byteReq), .byteAns(byteAns),
		.regReq(regReq), .regRdata(regRdata), .irq(irq));
	host_pkt_model host (.ref_clk(ref_clk), .nrst(nrst), .pktReady(pktReady),
		.go(go), .slow(slow), .words(words), .perr(perr), .pktValid(pktValid),
		.pktWord(pktWord), .pktParityErr(pktParityErr), .busy(busy));
	function automatic logic [52:0] key_of(tape_hdr_pkg::cmd_s c);
		return {c.op, c.mode, c.ackOwner, c.clearVolumeCheck,
			c.reverseRereadOrder, c.byteOrderSwap, c.completionInterruptEnable,
			c.packetWords, c.bufAddr, c.byteCount};
	endfunction
	function automatic logic [6:0] ref_dec(logic [4:0] c, logic [3:0] m);
		case (c)
		5'h01: return {m < 4'h4, tape_hdr_pkg::OP_READ, 3'h4};
		5'h04: return {m == 4'h0, tape_hdr_pkg::OP_WRITE_CHAR, 3'h4};
		5'h05: return {m == 4'h0 || m == 4'h2, tape_hdr_pkg::OP_WRITE, 3'h4};
		5'h08: return {m < 4'h5, tape_hdr_pkg::OP_POSITION,
			m == 4'h4 ? 3'h1 : 3'h2};
		5'h09: return {m < 4'h3, tape_hdr_pkg::OP_FORMAT, 3'h2};
		5'h0b: return {m == 4'h0, tape_hdr_pkg::OP_INIT, 3'h1};
		5'h0f: return {m == 4'h0, tape_hdr_pkg::OP_STATUS, 3'h1};
		default: return 7'h00;
		endcase
	endfunction
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (!ok) begin
			miscompares++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic cmp_cmd(input exp_s e);
		chk(cmdReject === e.rej && cmdValid === !e.rej, "result kind");
		if (!e.rej)
			chk(key_of(cmd) === e.key, "decoded command");
		if (!e.rej && e.rr)
			chk({cmd.step0, cmd.step1} === e.st, "reread steps");
		if (!e.rej && e.key[45])
			chk(msgBufOwned === 1'b1, "buffer not owned");
	endtask
	task automatic cmp_reg(input logic [15:0] e);
		chk(regRdata === e, "register read");
	endtask
	task automatic cmp_byte(input logic [21:0] e);
		chk(byteAns.addr === e, "byte address");
	endtask
	task automatic reg_op(input logic w, input logic [3:0] a,
		input logic [15:0] d);
		if (!w)
			rq.push_back(d);
		regReq <= '{w, !w, a, w ? d : 16'h0000};
		@(posedge ref_clk);
		regReq <= '0;
		@(posedge ref_clk);
	endtask
	task automatic send(input logic [3:0][15:0] w, input logic [3:0] pe);
		exp_s e;
		logic [6:0] d;
		int n;
		d = ref_dec(w[0][4:0], w[0][11:8]);
		e.rej = !d[6] || w[0][6:5] != 2'h0 || pe != 4'h0;
		e.key = {d[5:3], w[0][11:8], w[0][15:12], w[0][7], d[2:0],
			a22 ? w[2][5:2] : 4'h0, w[2][1:0], w[1], w[3]};
		e.rr = d[5:3] == tape_hdr_pkg::OP_READ && w[0][9];
		e.st = w[0][8] ? {tape_hdr_pkg::MV_SPACE_FWD, tape_hdr_pkg::MV_READ_REV}
			: {tape_hdr_pkg::MV_SPACE_REV, tape_hdr_pkg::MV_READ_FWD};
		if (w[0][13])
			e.st = {e.st[3:0], e.st[7:4]};
		cq.push_back(e);
		n = resCount;
		words <= w;
		perr <= pe;
		slow <= 1'($urandom);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		for (int i = 0; i < 40 && resCount == n; i++)
			@(posedge ref_clk);
		if (resCount == n)
			chk(1'b0, "no packet result");
	endtask
	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		rdSeen <= regReq.rd;
		if (cmdValid === 1'b1 || cmdReject === 1'b1) begin
			resCount++;
			cmp_cmd(cq.pop_front());
		end
		if (rdSeen === 1'b1)
			cmp_reg(rq.pop_front());
		if (byteAns.valid === 1'b1)
			cmp_byte(bq.pop_front());
	end
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		finish_test();
	end
	initial begin
		{nrst, go, slow, msgBufRelease, a22} = 5'h00;
		words = '0;
		perr = 4'h0;
		byteReq = '0;
		regReq = '0;
		void'($urandom(32'h8d4c));
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		for (int a = 0; a < 4; a++)
			reg_op(1'b0, 4'(a), 16'h0000);
		reg_op(1'b1, 4'hf, 16'hffff);
		reg_op(1'b0, 4'hf, 16'h0000);
		for (int c = 0; c < 32; c++)
			for (int m = 0; m < 6; m++) begin
				if (c == 5) begin
					reg_op(1'b1, 4'h2, 16'h0001);
					reg_op(1'b0, 4'h2, 16'h0001);
					a22 = 1'b1;
				end
				msgBufRelease <= 1'($urandom);
				@(posedge ref_clk);
				msgBufRelease <= 1'b0;
				@(posedge ref_clk);
				h = 16'($urandom);
				h[4:0] = 5'(c);
				h[11:8] = 4'(m);
				if ($urandom_range(3, 0) != 0)
					h[6:5] = 2'h0;
				h[15] = !msgBufOwned;
				send({16'($urandom), 16'($urandom), 16'($urandom), h}, 4'h0);
			end
		for (int t = 0; t < 6; t++) begin
			h = hdrs[t];
			cnt = 16'($urandom_range(16, 1));
			ba = 22'($urandom);
			send({cnt, 10'($urandom), ba, h}, 4'h0);
			for (int i = 0; i < cnt; i++) begin
				k = (h[4:0] == 5'h01 && h[8]) ? 22'(cnt - 1 - i) : 22'(i);
				bq.push_back((ba + k) ^ 22'(h[12] && !h[3]));
				byteReq <= '{1'b1, 16'(i)};
				@(posedge ref_clk);
				byteReq <= '0;
				@(posedge ref_clk);
			end
		end
		reg_op(1'b1, 4'h0, 16'h0007);
		send({16'h1234, 16'h0000, 16'h5678, 16'h0408}, 4'h8);
		reg_op(1'b0, 4'h0, 16'h0006);
		reg_op(1'b1, 4'h0, 16'h0007);
		reg_op(1'b1, 4'h1, 16'h0002);
		send({16'h0001, 16'h0002, 16'h0003, 16'h0006}, 4'h0);
		reg_op(1'b0, 4'h0, 16'h0002);
		@(negedge ref_clk);
		chk(irq === 1'b1, "irq not raised");
		@(posedge ref_clk);
		reg_op(1'b1, 4'h1, 16'h0000);
		@(negedge ref_clk);
		chk(irq === 1'b0, "irq not masked");
		@(posedge ref_clk);
		reg_op(1'b1, 4'h1, 16'h0002);
		reg_op(1'b1, 4'h0, 16'h0002);
		reg_op(1'b0, 4'h0, 16'h0000);
		@(negedge ref_clk);
		chk(irq === 1'b0, "irq not cleared");
		for (int r = 0; r < 2; r++) begin
			@(posedge ref_clk);
			msgBufRelease <= 1'b1;
			@(posedge ref_clk);
			msgBufRelease <= 1'b0;
			@(negedge ref_clk);
			chk(msgBufOwned === 1'b0, "buffer not released");
			@(posedge ref_clk);
			if (r == 0)
				send({16'h0000, 16'h0000, 16'h0000, 16'h800f}, 4'h0);
		end
		chk(cq.size() == 0 && bq.size() == 0 && rq.size() == 0,
			"results missing");
		finish_test();
	end
endmodule
`default_nettype wire
